// [design/t8r_regs.svh]
// Notes on behaviour
// - While the sync hold bit is one, both prescaler reset bits keep written values.
// - Writing the sync hold bit to zero clears the shared bit, and the async bit unless in async mode awaiting the ack.
// - Async prescaler reset bit resets that prescaler, self-clears unless hold is set.
// - In async mode the async reset bit reads one until the reset completed.
// - Shared prescaler reset bit resets the shared prescaler, self-clears unless hold set.
// - Counter value register: 8-bit read/write at offset 0x46, resets to 0x00.
// - A CPU write to the counter suppresses the compare match on the next tick.
// - Compare A value is matched continuously; match sets flag or drives pin A.
// - Compare B value is matched continuously; match sets flag or drives pin B.
// - Compare B flag sets on match, clears by vector or writing one.
// - Compare A flag sets on match, clears by vector or writing one.
// - Overflow flag sets on overflow, clears by vector or writing one.
// - Compare B interrupt requested only with global enable, its enable and flag.
// - Compare A interrupt requested only with global enable, its enable and flag.
// - Overflow interrupt requested only with global enable, its enable and flag.
// - The overflow point depends on the three-bit waveform mode.
// - Each register except the mask at 0x6E also answers at an I/O address 0x20 lower, up to 0x3F.
// - Interrupt flag register sits at offset 0x35 and resets to 0x00.
// - Overflow at 0xFF in modes 0,2,3; at zero in phase modes; at top in 7.
`ifndef T8R_REGS_SVH
`define T8R_REGS_SVH

// ----------------------------------------------------------------------
// data-space offsets
// ----------------------------------------------------------------------
`define T8R_OFS_FLAGS     8'h35
`define T8R_OFS_GENERAL   8'h43
`define T8R_OFS_CTRL_A    8'h44
`define T8R_OFS_CTRL_B    8'h45
`define T8R_OFS_COUNT     8'h46
`define T8R_OFS_CMP_A     8'h47
`define T8R_OFS_CMP_B     8'h48
`define T8R_OFS_MASK      8'h6E
`define T8R_IO_SHIFT      8'h20
`define T8R_IO_LIMIT      8'h3F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define T8R_BIT_HOLD      7
`define T8R_BIT_ASYNC     1
`define T8R_BIT_SHARED    0
`define T8R_BIT_OVF       0
`define T8R_BIT_CMP_A     1
`define T8R_BIT_CMP_B     2
`define T8R_BIT_FORCE_A   7
`define T8R_BIT_FORCE_B   6
`define T8R_BIT_WAVE_HI   3

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define T8R_RST_BYTE      8'h00
`define T8R_MAX           8'hFF
`define T8R_BOTTOM        8'h00
`define T8R_PRE_BITS      10

`endif

// [design/t8r_pkg.sv]
package t8r_pkg;

  // waveform generation modes
  typedef enum logic [2:0] {
    T8R_NORMAL   = 3'b000,
    T8R_PHASE_FF = 3'b001,
    T8R_CTC      = 3'b010,
    T8R_FAST_FF  = 3'b011,
    T8R_RSVD4    = 3'b100,
    T8R_PHASE_A  = 3'b101,
    T8R_RSVD6    = 3'b110,
    T8R_FAST_A   = 3'b111
  } t8r_wave_e;

  // timer clock sources
  typedef enum logic [2:0] {
    T8R_STOP    = 3'b000,
    T8R_DIV1    = 3'b001,
    T8R_DIV8    = 3'b010,
    T8R_DIV64   = 3'b011,
    T8R_DIV256  = 3'b100,
    T8R_DIV1024 = 3'b101,
    T8R_EXT_FALL= 3'b110,
    T8R_EXT_RISE= 3'b111
  } t8r_clksel_e;

  // complete state of the timer
  typedef struct packed {
    logic [7:0]  rdata;
    logic        sync_hold_bit;
    logic        async_prescaler_reset;
    logic        shared_prescaler_reset;
    logic [1:0]  com_a;
    logic [1:0]  com_b;
    t8r_wave_e   waveform_mode;
    t8r_clksel_e clk_sel;
    logic [2:0]  irq_enable;
    logic [2:0]  flags;
    logic [7:0]  counter_value;
    logic [7:0]  compare_a_value;
    logic [7:0]  compare_b_value;
    logic        down;
    logic        block;
    logic [9:0]  pre;
    logic [2:0]  ext_sync;
    logic        ext_level;
    logic [2:0]  ack_sync;
    logic        ack_level;
    logic        pin_a;
    logic        pin_b;
    logic [2:0]  irq;
  } t8r_state_s;

endpackage : t8r_pkg

// [design/t8r_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "t8r_regs.svh"

module t8r_timer
  import t8r_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] bus_addr,
  input  wire logic       bus_io,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       global_irq_enable,
  input  wire logic [2:0] vector_ack,
  input  wire logic       async_mode,
  input  wire logic       async_reset_ack,
  input  wire logic       ext_clk_pin,
  output logic      [7:0] bus_rdata,
  output logic            irq_overflow,
  output logic            irq_compare_a,
  output logic            irq_compare_b,
  output logic            compare_a_pin,
  output logic            compare_b_pin,
  output logic            shared_reset_out,
  output logic            async_reset_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  t8r_state_s s;
  t8r_state_s next_s;

  // ----------------------------------------------------------------------
  // compare output pin behaviour
  // ----------------------------------------------------------------------
  // non-PWM: 01 toggle, 10 clear, 11 set; PWM: 10 normal, 11 inverted
  function automatic logic pin_next(
    input logic [1:0] com,
    input t8r_wave_e  mode,
    input logic       down,
    input logic       match,
    input logic       at_bottom,
    input logic       force_hit,
    input logic       cur
  );
    logic pwm_fast;
    logic pwm_phase;
    logic r;
    pwm_fast  = (mode == T8R_FAST_FF) || (mode == T8R_FAST_A);
    pwm_phase = (mode == T8R_PHASE_FF) || (mode == T8R_PHASE_A);
    r         = cur;
    if (com == 2'b00) begin
      r = 1'b0;                       // pin disconnected from the timer
    end else if (pwm_fast) begin
      if (com[1] && at_bottom) begin
        r = ~com[0];
      end else if (com[1] && match) begin
        r = com[0];
      end
    end else if (pwm_phase) begin
      if (com[1] && match) begin
        r = down ? ~com[0] : com[0];
      end
    end else if (match || force_hit) begin
      case (com)
        2'b01:   r = ~cur;
        2'b10:   r = 1'b0;
        2'b11:   r = 1'b1;
        default: r = cur;
      endcase
    end
    return r;
  endfunction : pin_next

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [7:0] eff_addr;
  logic       addr_ok;
  logic       wr_flags;
  logic       wr_general;
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_count;
  logic       wr_cmp_a;
  logic       wr_cmp_b;
  logic       wr_mask;

  // I/O addresses are data-space addresses lowered by the shift
  always_comb begin
    eff_addr = bus_io ? (bus_addr + `T8R_IO_SHIFT) : bus_addr;
    addr_ok  = !bus_io || (bus_addr <= `T8R_IO_LIMIT);
  end

  assign wr_flags   = bus_wr && addr_ok && (eff_addr == `T8R_OFS_FLAGS);
  assign wr_general = bus_wr && addr_ok && (eff_addr == `T8R_OFS_GENERAL);
  assign wr_ctrl_a  = bus_wr && addr_ok && (eff_addr == `T8R_OFS_CTRL_A);
  assign wr_ctrl_b  = bus_wr && addr_ok && (eff_addr == `T8R_OFS_CTRL_B);
  assign wr_count   = bus_wr && addr_ok && (eff_addr == `T8R_OFS_COUNT);
  assign wr_cmp_a   = bus_wr && addr_ok && (eff_addr == `T8R_OFS_CMP_A);
  assign wr_cmp_b   = bus_wr && addr_ok && (eff_addr == `T8R_OFS_CMP_B);
  assign wr_mask    = bus_wr && addr_ok && (eff_addr == `T8R_OFS_MASK);

  // ----------------------------------------------------------------------
  // prescaler taps and timer tick
  // ----------------------------------------------------------------------
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic pre_run;

  // taps are quiet while the shared reset holds the prescaler at zero
  assign pre_run = !s.shared_prescaler_reset;
  assign ext_rise = (s.ext_sync[1] == s.ext_sync[2])
                    && s.ext_sync[2] && !s.ext_level;
  assign ext_fall = (s.ext_sync[1] == s.ext_sync[2])
                    && !s.ext_sync[2] && s.ext_level;

  always_comb begin
    case (s.clk_sel)
      T8R_STOP:     tick = 1'b0;
      T8R_DIV1:     tick = pre_run;
      T8R_DIV8:     tick = pre_run && (&s.pre[2:0]);
      T8R_DIV64:    tick = pre_run && (&s.pre[5:0]);
      T8R_DIV256:   tick = pre_run && (&s.pre[7:0]);
      T8R_DIV1024:  tick = pre_run && (&s.pre[9:0]);
      T8R_EXT_FALL: tick = ext_fall;
      T8R_EXT_RISE: tick = ext_rise;
      default:      tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // counter sequence, overflow point and matches
  // ----------------------------------------------------------------------
  logic [7:0] top;
  logic       phase_mode;
  logic       at_top;
  logic       ovf_hit;
  logic       match_a;
  logic       match_b;
  logic       bottom_evt;
  logic       non_pwm;

  always_comb begin
    phase_mode = (s.waveform_mode == T8R_PHASE_FF)
                 || (s.waveform_mode == T8R_PHASE_A);
    non_pwm    = !phase_mode && (s.waveform_mode != T8R_FAST_FF)
                 && (s.waveform_mode != T8R_FAST_A);
    case (s.waveform_mode)
      T8R_CTC, T8R_PHASE_A, T8R_FAST_A: top = s.compare_a_value;
      default:                          top = `T8R_MAX;
    endcase
    at_top = (s.counter_value == top);
    // overflow point follows the mode
    case (s.waveform_mode)
      T8R_PHASE_FF, T8R_PHASE_A:
        ovf_hit = tick && s.down
                  && (s.counter_value == `T8R_BOTTOM);
      T8R_FAST_A:
        ovf_hit = tick && at_top;
      default:
        ovf_hit = tick && (s.counter_value == `T8R_MAX);
    endcase
    // a counter write blocks the match on the following tick
    match_a = tick && !s.block
              && (s.counter_value == s.compare_a_value);
    match_b = tick && !s.block
              && (s.counter_value == s.compare_b_value);
    bottom_evt = tick && at_top && !phase_mode;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic       force_a;
    logic       force_b;
    next_s   = s;
    flag_set = 3'b000;
    flag_clr = 3'b000;
    force_a  = wr_ctrl_b && non_pwm && bus_wdata[`T8R_BIT_FORCE_A];
    force_b  = wr_ctrl_b && non_pwm && bus_wdata[`T8R_BIT_FORCE_B];

    // input synchronisers; only stages 2 and 3 are looked at
    next_s.ext_sync = {s.ext_sync[1:0], ext_clk_pin};
    next_s.ack_sync = {s.ack_sync[1:0], async_reset_ack};
    if (s.ext_sync[1] == s.ext_sync[2]) begin
      next_s.ext_level = s.ext_sync[2];
    end
    if (s.ack_sync[1] == s.ack_sync[2]) begin
      next_s.ack_level = s.ack_sync[2];
    end

    // shared prescaler counts only while its reset is released
    if (s.shared_prescaler_reset) begin
      next_s.pre = 10'h000;
    end else begin
      next_s.pre = s.pre + 10'h001;
    end

    // prescaler reset control: hold keeps written bits, else self-clear
    if (wr_general) begin
      next_s.sync_hold_bit          = bus_wdata[`T8R_BIT_HOLD];
      next_s.async_prescaler_reset  = bus_wdata[`T8R_BIT_ASYNC];
      next_s.shared_prescaler_reset = bus_wdata[`T8R_BIT_SHARED];
    end else if (!s.sync_hold_bit) begin
      next_s.shared_prescaler_reset = 1'b0;
      // async side waits for the far prescaler to confirm its reset
      next_s.async_prescaler_reset = s.async_prescaler_reset
                                     && async_mode
                                     && !s.ack_level;
    end

    // configuration registers
    if (wr_ctrl_a) begin
      next_s.com_a = bus_wdata[7:6];
      next_s.com_b = bus_wdata[5:4];
      next_s.waveform_mode = t8r_wave_e'({s.waveform_mode[2],
                                          bus_wdata[1:0]});
    end
    if (wr_ctrl_b) begin
      next_s.waveform_mode = t8r_wave_e'({bus_wdata[`T8R_BIT_WAVE_HI],
                                          next_s.waveform_mode[1:0]});
      next_s.clk_sel = t8r_clksel_e'(bus_wdata[2:0]);
    end
    if (wr_mask) begin
      next_s.irq_enable = bus_wdata[2:0];
    end
    if (wr_cmp_a) begin
      next_s.compare_a_value = bus_wdata;
    end
    if (wr_cmp_b) begin
      next_s.compare_b_value = bus_wdata;
    end

    // counter: a CPU write wins over the tick and arms the block
    if (tick) begin
      next_s.block = 1'b0;
    end
    if (wr_count) begin
      next_s.counter_value = bus_wdata;
      next_s.block         = 1'b1;
    end else if (tick) begin
      if (phase_mode) begin
        if (!s.down && at_top) begin
          next_s.down          = 1'b1;
          next_s.counter_value = s.counter_value - 8'h01;
        end else if (s.down && (s.counter_value == `T8R_BOTTOM)) begin
          next_s.down          = 1'b0;
          next_s.counter_value = s.counter_value + 8'h01;
        end else if (s.down) begin
          next_s.counter_value = s.counter_value - 8'h01;
        end else begin
          next_s.counter_value = s.counter_value + 8'h01;
        end
      end else begin
        next_s.down = 1'b0;
        next_s.counter_value = at_top ? `T8R_BOTTOM
                                      : s.counter_value + 8'h01;
      end
    end

    // waveform pins; forced compares move the pin but set no flag
    next_s.pin_a = pin_next(s.com_a, s.waveform_mode, s.down, match_a,
                            bottom_evt, force_a, s.pin_a);
    next_s.pin_b = pin_next(s.com_b, s.waveform_mode, s.down, match_b,
                            bottom_evt, force_b, s.pin_b);

    // flags: set wins over a same-cycle clear
    flag_set[`T8R_BIT_OVF]   = ovf_hit;
    flag_set[`T8R_BIT_CMP_A] = match_a;
    flag_set[`T8R_BIT_CMP_B] = match_b;
    flag_clr = vector_ack | (wr_flags ? bus_wdata[2:0] : 3'b000);
    next_s.flags = (s.flags & ~flag_clr) | flag_set;

    // interrupt requests need global enable, local enable and flag
    next_s.irq = next_s.flags & next_s.irq_enable
                 & {3{global_irq_enable}};

    // read data, one cycle after the strobe; misses read zero
    next_s.rdata = `T8R_RST_BYTE;
    if (bus_rd && addr_ok) begin
      case (eff_addr)
        `T8R_OFS_FLAGS:   next_s.rdata = {5'h00, s.flags};
        `T8R_OFS_GENERAL: next_s.rdata = {s.sync_hold_bit, 5'h00,
                                          s.async_prescaler_reset,
                                          s.shared_prescaler_reset};
        `T8R_OFS_CTRL_A:  next_s.rdata = {s.com_a, s.com_b, 2'b00,
                                          s.waveform_mode[1:0]};
        `T8R_OFS_CTRL_B:  next_s.rdata = {4'h0, s.waveform_mode[2],
                                          s.clk_sel};
        `T8R_OFS_COUNT:   next_s.rdata = s.counter_value;
        `T8R_OFS_CMP_A:   next_s.rdata = s.compare_a_value;
        `T8R_OFS_CMP_B:   next_s.rdata = s.compare_b_value;
        `T8R_OFS_MASK:    next_s.rdata = {5'h00, s.irq_enable};
        default:          next_s.rdata = `T8R_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // synchronous reset; every field lands on a constant
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign bus_rdata        = s.rdata;
  assign irq_overflow     = s.irq[`T8R_BIT_OVF];
  assign irq_compare_a    = s.irq[`T8R_BIT_CMP_A];
  assign irq_compare_b    = s.irq[`T8R_BIT_CMP_B];
  assign compare_a_pin    = s.pin_a;
  assign compare_b_pin    = s.pin_b;
  assign shared_reset_out = s.shared_prescaler_reset;
  assign async_reset_out  = s.async_prescaler_reset;

endmodule : t8r_timer

`default_nettype wire

// [testbench/t8r_timer_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module t8r_timer_chk (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] bus_addr,
  input wire logic       bus_io,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic       global_irq_enable,
  input wire logic [2:0] vector_ack,
  input wire logic       async_mode,
  input wire logic       async_reset_ack,
  input wire logic       ext_clk_pin,
  input wire logic [7:0] bus_rdata,
  input wire logic       irq_overflow,
  input wire logic       irq_compare_a,
  input wire logic       irq_compare_b,
  input wire logic       compare_a_pin,
  input wire logic       compare_b_pin,
  input wire logic       shared_reset_out,
  input wire logic       async_reset_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic       gen_wr;
  logic [2:0] ack_low;
  // write to the general control register in either address space
  assign gen_wr = bus_wr && (bus_io ? bus_addr == 8'h23 : bus_addr == 8'h43);
  // cycles since the ack was high; saturates so a long wait never wraps
  always_ff @(posedge ref_clk) begin
    if (!nrst || async_reset_ack)
      ack_low <= 3'h0;
    else if (ack_low != 3'h7)
      ack_low <= ack_low + 3'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ovf_irq_gate: assert property (
    irq_overflow |-> $past(global_irq_enable))
    else $error("overflow request without global enable");
  a_cmpa_irq_gate: assert property (
    irq_compare_a |-> $past(global_irq_enable))
    else $error("compare a request without global enable");
  a_cmpb_irq_gate: assert property (
    irq_compare_b |-> $past(global_irq_enable))
    else $error("compare b request without global enable");
  a_shared_rise_cause: assert property (
    $rose(shared_reset_out) |-> $past(gen_wr && bus_wdata[0]))
    else $error("shared reset rose without a write");
  a_shared_self_clear: assert property (
    (gen_wr && !bus_wdata[7]) ##1 !gen_wr |=> !shared_reset_out)
    else $error("shared reset did not clear");
  a_async_self_clear: assert property (
    (gen_wr && !bus_wdata[7] && !async_mode) ##1 (!gen_wr && !async_mode)
    |=> !async_reset_out)
    else $error("async reset did not clear");
  a_hold_keeps_bits: assert property (
    (gen_wr && bus_wdata[7] && bus_wdata[0]) ##1 (!gen_wr) [*4]
    |-> shared_reset_out)
    else $error("shared reset dropped while held");
  a_async_waits_ack: assert property (
    async_mode && async_reset_out && !async_reset_ack && ack_low >= 3'h5 &&
    !gen_wr |=> async_reset_out)
    else $error("async reset dropped before completion");
  a_read_idle_zero: assert property (
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_io_over_limit: assert property (
    bus_rd && bus_io && bus_addr > 8'h3F |=> bus_rdata == 8'h00)
    else $error("io read above limit returned data");
endmodule : t8r_timer_chk

bind t8r_timer t8r_timer_chk u_t8r_timer_chk (
  .ref_clk, .nrst, .bus_addr, .bus_io, .bus_wr, .bus_rd, .bus_wdata,
  .global_irq_enable, .vector_ack, .async_mode, .async_reset_ack,
  .ext_clk_pin, .bus_rdata, .irq_overflow, .irq_compare_a, .irq_compare_b,
  .compare_a_pin, .compare_b_pin, .shared_reset_out, .async_reset_out
);

`default_nettype wire

// [testbench/t8r_async_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module t8r_async_peer (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] ack_delay,
  input  wire logic       async_reset_out,
  output logic            async_reset_ack
);
  int wait_cnt;
  // far domain finishes its reset after ack_delay + 1 ref_clk cycles; ack drops
  // once the request is gone so the next request starts clean
  always @(posedge ref_clk) begin
    if (!nrst || !async_reset_out) begin
      wait_cnt        <= 0;
      async_reset_ack <= 1'b0;
    end else if (wait_cnt < int'(ack_delay))
      wait_cnt <= wait_cnt + 1;
    else
      async_reset_ack <= 1'b1;
  end
endmodule : t8r_async_peer

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       ref_clk = 1'b0, nrst = 1'b0, bus_io = 1'b0;
  logic       bus_wr = 1'b0, bus_rd = 1'b0, glb = 1'b0, amode = 1'b0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, rdata;
  logic [2:0] vack = 3'h0;
  logic [3:0] dly = 4'h8;
  logic       ack, irq_o, irq_a, irq_b, sh_out, as_out, pin_a, pin_b;
  int fail_count = 0, cmp_count = 0, cyc_count = 0, seed = 87;
  int m_cnt = 0, m_ca = 0, m_cb = 0, m_fl = 0, v;
  int exp_q[$];
  logic [7:0] offs [5] = '{8'h35, 8'h43, 8'h46, 8'h47, 8'h48};

  t8r_timer u_t8r_timer (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_io(bus_io), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .global_irq_enable(glb), .vector_ack(vack), .async_mode(amode),
    .async_reset_ack(ack), .ext_clk_pin(1'b0), .bus_rdata(rdata),
    .irq_overflow(irq_o), .irq_compare_a(irq_a), .irq_compare_b(irq_b),
    .compare_a_pin(pin_a), .compare_b_pin(pin_b), .shared_reset_out(sh_out),
    .async_reset_out(as_out));
  t8r_async_peer u_t8r_async_peer (.ref_clk(ref_clk), .nrst(nrst),
    .ack_delay(dly), .async_reset_out(as_out), .async_reset_ack(ack));

  // ----------------------------------------------------------------
  // clock, timeout and bus tasks
  // ----------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;
  // the whole run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // tasks start and end 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    {bus_addr, bus_io, bus_wdata, bus_wr} = {a, io, d, 1'b1};
    // strobe drops on the taking edge so a following call may raise it
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] e);
    {bus_addr, bus_io, bus_rd} = {a, io, 1'b1};
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask : rd

  // reference counter in normal mode; a counter write masks the compare matches on the first tick
  task automatic run(input int n);
    wr(8'h45, 1'b0, 8'h01);
    cyc(n - 1);
    wr(8'h45, 1'b0, 8'h00);
    for (int i = 0; i < n; i++) begin
      if (i > 0 && m_cnt == m_ca) m_fl |= 2;
      if (i > 0 && m_cnt == m_cb) m_fl |= 4;
      if (m_cnt == 255) m_fl |= 1;
      m_cnt = (m_cnt + 1) % 256;
    end
  endtask : run

  task automatic irqs(input logic [2:0] e);
    cyc(1);
    chk("irq lines", {5'h0, e}, {5'h0, irq_b, irq_a, irq_o});
  endtask : irqs

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    foreach (offs[i]) begin
      rd(offs[i], 1'b0, 8'h00);
      rd(offs[i] - 8'h20, 1'b1, 8'h00);
    end
    // random compare values written in one space, read back in the other
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      exp_q.push_back(v & 32'hFF);
      wr(8'h27 + 8'(i % 2), 1'b1, 8'(v));
      rd(8'h47 + 8'(i % 2), 1'b0, 8'(exp_q.pop_front()));
    end
    rd(8'h50, 1'b0, 8'h00);
    rd(8'h40, 1'b1, 8'h00);
    // count through compare A and the overflow point, B after the wrap
    {m_ca, m_cb, m_cnt} = {32'hF8, 32'h02, 32'hF0};
    wr(8'h47, 1'b0, 8'hF8);
    wr(8'h48, 1'b0, 8'h02);
    wr(8'h6E, 1'b0, 8'h07);
    wr(8'h46, 1'b0, 8'hF0); // counter is stopped, no match lost
    run(20);
    rd(8'h46, 1'b0, 8'(m_cnt));
    rd(8'h35, 1'b0, 8'(m_fl));
    irqs(3'h0);
    glb = 1'b1;
    irqs(3'(m_fl));
    wr(8'h6E, 1'b0, 8'h03);
    irqs(3'h3);
    vack = 3'h1;
    cyc(1);
    vack = 3'h0;
    wr(8'h35, 1'b0, 8'h00);
    rd(8'h35, 1'b0, 8'h06);
    wr(8'h35, 1'b0, 8'h02);
    wr(8'h15, 1'b1, 8'h04);
    rd(8'h35, 1'b0, 8'h00);
    glb = 1'b0;
    m_fl = 0;
    // a counter write masks the match on the following tick only
    // both pins toggle on their match, so a blocked match leaves them low
    wr(8'h44, 1'b0, 8'h50);
    {m_ca, m_cnt} = {32'h20, 32'h20};
    wr(8'h47, 1'b0, 8'h20);
    wr(8'h46, 1'b0, 8'h20);
    run(3);
    rd(8'h35, 1'b0, 8'(m_fl));
    chk("pins", 8'h00, {6'h0, pin_b, pin_a});
    m_cnt = 32'h1E;
    wr(8'h46, 1'b0, 8'h1E);
    run(3);
    rd(8'h35, 1'b0, 8'(m_fl));
    chk("pins", 8'h01, {6'h0, pin_b, pin_a});
    // forced compare on B moves the pin and sets no flag
    wr(8'h45, 1'b0, 8'h40);
    chk("pins", 8'h03, {6'h0, pin_b, pin_a});
    rd(8'h35, 1'b0, 8'(m_fl));
    // held prescaler reset stops the divided clock
    wr(8'h43, 1'b0, 8'h81);
    wr(8'h45, 1'b0, 8'h02);
    cyc(40);
    wr(8'h45, 1'b0, 8'h00);
    chk("shared reset", 8'h01, {7'h0, sh_out});
    rd(8'h46, 1'b0, 8'(m_cnt));
    wr(8'h43, 1'b0, 8'h83);
    cyc(3);
    chk("both resets held", 8'h03, {6'h0, as_out, sh_out});
    wr(8'h43, 1'b0, 8'h00);
    cyc(1);
    chk("both resets", 8'h00, {6'h0, as_out, sh_out});
    wr(8'h43, 1'b0, 8'h03);
    chk("reset pulse", 8'h03, {6'h0, as_out, sh_out});
    cyc(1);
    chk("self clear", 8'h00, {6'h0, as_out, sh_out});
    // async mode: bit stays until the far domain acks, slow then prompt
    amode = 1'b1;
    for (int d = 0; d < 2; d++) begin
      dly = d ? 4'h1 : 4'hA;
      wr(8'h43, 1'b0, 8'h02);
      cyc(3);
      chk("async pending", 8'h01, {7'h0, as_out});
      for (int i = 0; i < 30 && as_out; i++)
        cyc(1);
      chk("async done", 8'h00, {7'h0, as_out});
      cyc(8);
    end
    test_done();
  end
endmodule : testbench

`default_nettype wire
